//--- design/sfpwm_params.svh
/*
  Constants of the sixteen-bit fast PWM timer: mode codes, fixed TOP
  values, prescaler choices, BOTTOM and MAX.
  Assumes it is included by the package, the design module and the bench.
*/
`ifndef SFPWM_PARAMS_SVH
`define SFPWM_PARAMS_SVH

`define SFPWM_TOP_8BIT    16'h00FF
`define SFPWM_TOP_9BIT    16'h01FF
`define SFPWM_TOP_10BIT   16'h03FF
`define SFPWM_TOP_MIN     16'h0003
`define SFPWM_MAX         16'hFFFF
`define SFPWM_BOTTOM      16'h0000

`define SFPWM_WGM_PC8     4'h1
`define SFPWM_WGM_PC9     4'h2
`define SFPWM_WGM_PC10    4'h3
`define SFPWM_WGM_FP8     4'h5
`define SFPWM_WGM_FP9     4'h6
`define SFPWM_WGM_FP10    4'h7
`define SFPWM_WGM_PCICR   4'hA
`define SFPWM_WGM_PCOCR   4'hB
`define SFPWM_WGM_FPICR   4'hE
`define SFPWM_WGM_FPOCR   4'hF

`define SFPWM_COM_OFF     2'h0
`define SFPWM_COM_TOGGLE  2'h1
`define SFPWM_COM_NONINV  2'h2
`define SFPWM_COM_INV     2'h3

`define SFPWM_DIV_1       10'h000
`define SFPWM_DIV_8       10'h007
`define SFPWM_DIV_64      10'h03F
`define SFPWM_DIV_256     10'h0FF
`define SFPWM_DIV_1024    10'h3FF

`define SFPWM_CS_STOP     3'h0
`define SFPWM_CS_1        3'h1
`define SFPWM_CS_8        3'h2
`define SFPWM_CS_64       3'h3
`define SFPWM_CS_256      3'h4
`define SFPWM_CS_1024     3'h5

`endif

//--- design/sfpwm_pkg.sv
/*
  Types of the sixteen-bit fast PWM timer.
  Assumes sfpwm_params.svh is on the include path.
*/
package sfpwm_pkg;
  `include "sfpwm_params.svh"

  typedef enum logic [1:0] {
    SFPWM_SINGLE,
    SFPWM_DUAL,
    SFPWM_OTHER
  } sfpwm_slope_e;

  // Software write strobes with data
  typedef struct packed {
    logic        wr_a;
    logic        wr_b;
    logic        wr_icr;
    logic [15:0] data;
  } sfpwm_wr_s;

  typedef struct packed {
    logic        overflow;
    logic        match_a;
    logic        match_b;
    logic        capture;
  } sfpwm_flags_s;

  typedef struct packed {
    logic [9:0]   presc;
    logic         tick;
    logic [15:0]  count;
    logic         down;
    logic [15:0]  buf_a;
    logic [15:0]  buf_b;
    logic [15:0]  cmp_a;
    logic [15:0]  cmp_b;
    logic [15:0]  icr;
    logic         oc_a;
    logic         oc_b;
    sfpwm_flags_s flags;
    logic         pin_a;
    logic         pin_a_oe;
    logic         pin_b;
    logic         pin_b_oe;
  } sfpwm_state_s;
endpackage

//--- design/sfpwm_timer.sv
/*
  Sixteen-bit timer waveform generator, fast PWM and phase correct PWM,
  two compare channels. Software strobes and flag clears arrive from
  logic on clk; the pin outputs go to the port pad.
*/
`timescale 1ns/1ps
`include "sfpwm_params.svh"

module sfpwm_timer
  import sfpwm_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [3:0]   waveform_mode_select,
  input  wire logic [2:0]   clock_select,
  input  wire logic [1:0]   channel_a_output_mode,
  input  wire logic [1:0]   channel_b_output_mode,
  input  wire logic         pin_direction_bit_a,
  input  wire logic         pin_direction_bit_b,
  input  wire logic         port_data_a,
  input  wire logic         port_data_b,
  input  wire sfpwm_wr_s    wr,
  input  wire sfpwm_flags_s flag_clear,
  output logic [15:0]       count_value,
  output sfpwm_flags_s      flags,
  output logic              channel_a_output,
  output logic              channel_a_output_oe,
  output logic              channel_b_output,
  output logic              channel_b_output_oe
);

  // Refused at elaboration: the counter logic is fixed at 16 bits
  if (WIDTH != 16)
  begin : g_width_chk
    $error("sfpwm_timer serves only a 16-bit counter");
  end

  sfpwm_state_s q;
  sfpwm_state_s next_q;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [9:0] div_mask(input logic [2:0] cs);
    case (cs)
      `SFPWM_CS_1:    div_mask = `SFPWM_DIV_1;
      `SFPWM_CS_8:    div_mask = `SFPWM_DIV_8;
      `SFPWM_CS_64:   div_mask = `SFPWM_DIV_64;
      `SFPWM_CS_256:  div_mask = `SFPWM_DIV_256;
      default:        div_mask = `SFPWM_DIV_1024;
    endcase
  endfunction

  // Bits above the fixed resolution are forced to zero
  function automatic logic [15:0] mask_cmp(input logic [3:0]  wgm,
                                           input logic [15:0] v);
    case (wgm)
      `SFPWM_WGM_FP8, `SFPWM_WGM_PC8:   mask_cmp = v & `SFPWM_TOP_8BIT;
      `SFPWM_WGM_FP9, `SFPWM_WGM_PC9:   mask_cmp = v & `SFPWM_TOP_9BIT;
      `SFPWM_WGM_FP10, `SFPWM_WGM_PC10: mask_cmp = v & `SFPWM_TOP_10BIT;
      default:                          mask_cmp = v;
    endcase
  endfunction

  function automatic logic pwm_act(input logic [1:0] com,
                                   input logic       cur,
                                   input logic       level);
    case (com)
      `SFPWM_COM_NONINV: pwm_act = level;
      `SFPWM_COM_INV:    pwm_act = ~level;
      default:           pwm_act = cur;
    endcase
  endfunction

  // ==========================================================
  // Mode decode
  // ==========================================================
  sfpwm_slope_e slope;
  logic [15:0]  top;
  logic         top_ocr;
  logic         top_icr;

  always_comb
  begin
    top_ocr = 1'b0;
    top_icr = 1'b0;
    slope   = SFPWM_OTHER;
    top     = `SFPWM_MAX;
    case (waveform_mode_select)
      `SFPWM_WGM_FP8, `SFPWM_WGM_PC8:   top = `SFPWM_TOP_8BIT;
      `SFPWM_WGM_FP9, `SFPWM_WGM_PC9:   top = `SFPWM_TOP_9BIT;
      `SFPWM_WGM_FP10, `SFPWM_WGM_PC10: top = `SFPWM_TOP_10BIT;
      `SFPWM_WGM_FPICR, `SFPWM_WGM_PCICR:
      begin
        top     = q.icr;
        top_icr = 1'b1;
      end
      `SFPWM_WGM_FPOCR, `SFPWM_WGM_PCOCR:
      begin
        top     = q.cmp_a;
        top_ocr = 1'b1;
      end
      default: top = `SFPWM_MAX;
    endcase
    case (waveform_mode_select)
      `SFPWM_WGM_FP8, `SFPWM_WGM_FP9, `SFPWM_WGM_FP10,
      `SFPWM_WGM_FPICR, `SFPWM_WGM_FPOCR:
        slope = SFPWM_SINGLE;
      `SFPWM_WGM_PC8, `SFPWM_WGM_PC9, `SFPWM_WGM_PC10,
      `SFPWM_WGM_PCICR, `SFPWM_WGM_PCOCR:
        slope = SFPWM_DUAL;
      default: slope = SFPWM_OTHER;
    endcase
  end

  // ==========================================================
  // Next state
  // ==========================================================
  logic at_top;
  logic at_bot;
  logic m_a;
  logic m_b;

  always_comb
  begin
    next_q = q;
    // Clears go first, so a hardware set in the same cycle wins
    next_q.flags = q.flags & ~flag_clear;
    at_top = (q.count == top);
    at_bot = (q.count == `SFPWM_BOTTOM);
    // Match fires above TOP only while a lowered TOP leaves the count above it: wrapping through MAX, or falling in dual slope
    m_a    = (q.count == q.cmp_a);
    m_b    = (q.count == q.cmp_b);

    // Prescaler: tick registered so it is a clean one-cycle enable
    next_q.presc = q.presc + 10'h001;
    next_q.tick  = (clock_select != `SFPWM_CS_STOP) &&
                   ((q.presc & div_mask(clock_select)) ==
                    div_mask(clock_select));

    // Writes land in the buffers at any time; ICR acts at once
    if (wr.wr_a)
      next_q.buf_a = mask_cmp(waveform_mode_select, wr.data);
    if (wr.wr_b)
      next_q.buf_b = mask_cmp(waveform_mode_select, wr.data);
    if (wr.wr_icr)
      next_q.icr = wr.data;

    // Modes without waveform logic: compare registers follow writes
    if (slope == SFPWM_OTHER)
    begin
      next_q.cmp_a = next_q.buf_a;
      next_q.cmp_b = next_q.buf_b;
    end

    if (q.tick && slope != SFPWM_OTHER)
    begin
      if (m_a)
        next_q.flags.match_a = 1'b1;
      if (m_b)
        next_q.flags.match_b = 1'b1;
      if (slope == SFPWM_SINGLE)
      begin
        // TOP below count wraps through MAX; plain increment does it
        next_q.count = at_top ? `SFPWM_BOTTOM
                              : q.count + 16'h0001;
        next_q.down  = 1'b0;
        if (at_top)
        begin
          next_q.flags.overflow = 1'b1;
          if (top_ocr)
            next_q.flags.match_a = 1'b1;
          if (top_icr)
            next_q.flags.capture = 1'b1;
          next_q.cmp_a = q.buf_a;
          next_q.cmp_b = q.buf_b;
          // Set at the TOP-to-zero step; a match at TOP outranks it
          if (!m_a)
            next_q.oc_a = pwm_act(channel_a_output_mode, q.oc_a,
                                  1'b1);
          if (!m_b)
            next_q.oc_b = pwm_act(channel_b_output_mode, q.oc_b, 1'b1);
        end
        if (m_a)
        begin
          if (channel_a_output_mode == `SFPWM_COM_TOGGLE)
          begin
            if (waveform_mode_select == `SFPWM_WGM_FPOCR)
              next_q.oc_a = ~q.oc_a;
          end
          else
            next_q.oc_a = pwm_act(channel_a_output_mode, q.oc_a,
                                  1'b0);
        end
        if (m_b)
          next_q.oc_b = pwm_act(channel_b_output_mode, q.oc_b, 1'b0);
      end
      else
      begin
        // Dual slope: direction turns at TOP and at BOTTOM
        if (at_top)
        begin
          next_q.down  = 1'b1;
          next_q.cmp_a = q.buf_a;
          next_q.cmp_b = q.buf_b;
          if (top_ocr)
            next_q.flags.match_a = 1'b1;
          if (top_icr)
            next_q.flags.capture = 1'b1;
        end
        else if (at_bot)
        begin
          next_q.down           = 1'b0;
          next_q.flags.overflow = 1'b1;
        end
        if (at_top)
          next_q.count = q.count - 16'h0001;
        else if (at_bot)
          next_q.count = q.count + 16'h0001;
        else
          next_q.count = q.down ? q.count - 16'h0001
                                : q.count + 16'h0001;
        // Direction of the coming step decides set or clear at the turns
        if (m_a)
        begin
          if (channel_a_output_mode == `SFPWM_COM_TOGGLE)
          begin
            if (waveform_mode_select == `SFPWM_WGM_PCOCR)
              next_q.oc_a = ~q.oc_a;
          end
          else
            next_q.oc_a = pwm_act(channel_a_output_mode, q.oc_a,
                                  next_q.down);
        end
        if (m_b)
          next_q.oc_b = pwm_act(channel_b_output_mode, q.oc_b, next_q.down);
      end
    end

    // Pin: generator overrides port data when output mode is nonzero
    next_q.pin_a    = (channel_a_output_mode != `SFPWM_COM_OFF)
                      ? next_q.oc_a : port_data_a;
    next_q.pin_b    = (channel_b_output_mode != `SFPWM_COM_OFF)
                      ? next_q.oc_b : port_data_b;
    next_q.pin_a_oe = pin_direction_bit_a;
    next_q.pin_b_oe = pin_direction_bit_b;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else if (clk_en)
      q <= next_q;
  end

  assign count_value         = q.count;
  assign flags               = q.flags;
  assign channel_a_output    = q.pin_a;
  assign channel_a_output_oe = q.pin_a_oe;
  assign channel_b_output    = q.pin_b;
  assign channel_b_output_oe = q.pin_b_oe;

  // ==========================================================
  // Assertions
  // ==========================================================
  logic fast;
  assign fast = (slope == SFPWM_SINGLE);

  sequence s_top_tick;
    clk_en && q.tick && fast && at_top;
  endsequence

  a_top_wraps_zero: assert property (
    @(posedge clk) disable iff (rst)
    s_top_tick |=> q.count == `SFPWM_BOTTOM)
    else $error("count did not clear after TOP");

  a_top_sets_ovf: assert property (
    @(posedge clk) disable iff (rst)
    s_top_tick |=> q.flags.overflow)
    else $error("overflow flag missing at TOP");

  a_top_ocr_flag: assert property (
    @(posedge clk) disable iff (rst)
    s_top_tick ##0 top_ocr |=> q.flags.match_a)
    else $error("channel A flag missing at register TOP");

  a_buffer_load: assert property (
    @(posedge clk) disable iff (rst)
    s_top_tick |=> q.cmp_a == $past(q.buf_a))
    else $error("compare not reloaded at TOP");

  a_fixed_top: assert property (
    @(posedge clk) disable iff (rst)
    waveform_mode_select == `SFPWM_WGM_FP8 && clk_en && q.tick
    |=> q.count <= `SFPWM_TOP_8BIT || $past(q.count) > `SFPWM_TOP_8BIT)
    else $error("8-bit mode passed its fixed TOP");

  a_frozen_count: assert property (
    @(posedge clk) disable iff (rst)
    !(clk_en && q.tick) |=> $stable(q.count))
    else $error("count moved without a tick");

  a_match_clears: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && q.tick && fast && m_a && !at_top
    && channel_a_output_mode == `SFPWM_COM_NONINV
    |=> !q.oc_a && !q.pin_a)
    else $error("non-inverted output not cleared on match");

  a_pin_oe: assert property (
    @(posedge clk) disable iff (rst)
    clk_en |=> q.pin_a_oe == $past(pin_direction_bit_a))
    else $error("pin enable not following direction bit");

  a_reg_top_climb: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && q.tick && fast && (top_ocr || top_icr) && !at_top
    |=> q.count == $past(q.count) + 16'h0001)
    else $error("register TOP count did not climb");

  a_clear_works: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && flag_clear.overflow && !(q.tick && (at_top || at_bot))
    |=> !q.flags.overflow)
    else $error("overflow flag not cleared");

  a_pin_override: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && channel_a_output_mode == `SFPWM_COM_OFF
    |=> q.pin_a == $past(port_data_a))
    else $error("port data not passed with generator off");

  a_dual_turn: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && q.tick && slope == SFPWM_DUAL && at_top && !at_bot
    |=> q.down && q.count == $past(q.count) - 16'h0001)
    else $error("dual slope did not turn down at TOP");

endmodule // sfpwm_timer

//--- tb/sfpwm_timer_tb.sv
/*
  Self-checking bench for the sixteen-bit PWM timer: a cycle model of
  counter, buffers, pins and single slope flags follows the design at every edge.
  Assumes the package is compiled first and design/ is on the include path.
*/
`timescale 1ns/1ps
`include "sfpwm_params.svh"

module sfpwm_timer_tb
  import sfpwm_pkg::*;
;
  logic         clk;
  logic         rst;
  logic         clk_en;
  logic [3:0]   wms;
  logic [2:0]   csel;
  logic [1:0]   oma;
  logic [1:0]   omb;
  logic         dir_a;
  logic         dir_b;
  logic         pd_a;
  logic         pd_b;
  sfpwm_wr_s    wr;
  sfpwm_flags_s fclr;
  logic [15:0]  cnt;
  sfpwm_flags_s flags;
  logic         out_a;
  logic         oe_a;
  logic         out_b;
  logic         oe_b;
  int           fails;
  int           comparisons;
  bit           act;
  logic [15:0]  mc;
  logic         mdn;
  logic [15:0]  mbuf [2];
  logic [15:0]  mcmp [2];
  logic [15:0]  micr;
  logic [1:0]   moc;
  sfpwm_flags_s mfl;
  int           since;
  int           nchg;

  sfpwm_timer dut_u (
    .clk                  (clk),
    .rst                  (rst),
    .clk_en               (clk_en),
    .waveform_mode_select (wms),
    .clock_select         (csel),
    .channel_a_output_mode(oma),
    .channel_b_output_mode(omb),
    .pin_direction_bit_a  (dir_a),
    .pin_direction_bit_b  (dir_b),
    .port_data_a          (pd_a),
    .port_data_b          (pd_b),
    .wr                   (wr),
    .flag_clear           (fclr),
    .count_value          (cnt),
    .flags                (flags),
    .channel_a_output     (out_a),
    .channel_a_output_oe  (oe_a),
    .channel_b_output     (out_b),
    .channel_b_output_oe  (oe_b)
  );

  // ==========================================================
  // Model helpers
  function automatic logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: return `SFPWM_TOP_8BIT;
      4'h2, 4'h6: return `SFPWM_TOP_9BIT;
      4'h3, 4'h7: return `SFPWM_TOP_10BIT;
      4'hA, 4'hE: return micr;
      default:    return mcmp[0];
    endcase
  endfunction

  function automatic bit dual(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
  endfunction

  function automatic int div_of(input logic [2:0] c);
    case (c)
      3'h0:    return 0;
      3'h1:    return 1;
      3'h2:    return 8;
      3'h3:    return 64;
      3'h4:    return 256;
      default: return 1024;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s seen %h exp %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Monitor: settles 2 ns after each edge, then steps the model
  always @(posedge clk)
  begin
    logic [15:0]  top;
    logic [15:0]  nx;
    logic [1:0]   om;
    sfpwm_flags_s ev;
    int           d;
    #2;
    if (rst)
    begin
      mc = '0;
      mdn = 1'b0;
      mbuf = '{2{16'h0000}};
      mcmp = '{2{16'h0000}};
      micr = '0;
      moc = '0;
      mfl = '0;
      since = 0;
      nchg = 0;
    end
    else
    begin
      top = top_of(wms);
      d = div_of(csel);
      ev = '0;
      if (act && clk_en)
      begin
        since++;
        if (cnt !== mc)
        begin
          if (!dual(wms))
            nx = (mc == top) ? 16'h0000 : mc + 16'h0001;
          else if (mdn ? mc == 16'h0000 : mc == top)
          begin
            mdn = !mdn;
            nx = mdn ? mc - 16'h0001 : 16'h0001;
          end
          else
            nx = mdn ? mc - 16'h0001 : mc + 16'h0001;
          chk(cnt, nx, "count step");
          if (nchg > 0 || d == 0)
            chk(since, d, "step spacing");
          since = 0;
          nchg++;
          for (int ch = 0; ch < 2; ch++)
          begin
            om = ch ? omb : oma;
            if (mc == mcmp[ch] && om == 2'h1 && ch == 0)
              moc[ch] = !moc[ch];
            else if (mc == mcmp[ch] && om[1])
              moc[ch] = om[0] ^ (dual(wms) && nx < mc);
            else if (mc == top && om[1] && !dual(wms))
              moc[ch] = !om[0];
          end
          ev.overflow = (mc == top);
          ev.match_a = (mc == mcmp[0]);
          ev.match_b = (mc == mcmp[1]);
          ev.capture = (wms == 4'hE && mc == top);
          if (mc == top)
            mcmp = mbuf;
          mc = nx;
        end
        else if (nchg > 0 && d > 0)
          chk(since < d, 1, "late step");
        mfl = (mfl & ~fclr) | ev;
        if (!dual(wms))
          chk(flags, mfl, "flags");
        if (dir_a)
          chk(out_a, oma == 2'h0 ? pd_a : moc[0], "pin a");
        if (dir_b)
          chk(out_b, omb == 2'h0 ? pd_b : moc[1], "pin b");
        chk({oe_a, oe_b}, {dir_a, dir_b}, "pin dir");
      end
      else if (act)
      begin
        chk(cnt, mc, "frozen count");
        if (!dual(wms))
          chk(flags, mfl, "frozen flags");
      end
      if (clk_en)
      begin
        nx = (wms inside {4'h5, 4'h6, 4'h7}) ? wr.data & top : wr.data;
        if (wr.wr_a)
          mbuf[0] = nx;
        if (wr.wr_b)
          mbuf[1] = nx;
        if (wr.wr_icr)
          micr = wr.data;
        if (!dual(wms) && !(wms inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}))
          mcmp = mbuf;
      end
    end
  end

  // ==========================================================
  // One scenario: reset, load compares in a non-PWM mode, then run
  task automatic run_case(input logic [3:0] m, input logic [2:0] cs,
                          input logic [1:0] oa, input logic [1:0] ob,
                          input logic [15:0] ca, input logic [15:0] cb,
                          input logic [15:0] ic, input sfpwm_wr_s mw,
                          input logic [15:0] at, input int n,
                          input bit ren);
    bit done;
    bit hit;
    done = 1'b0;
    act = 1'b0;
    {wms, oma, omb, dir_a, dir_b, pd_a, pd_b} = '0;
    // Divider settles in reset so no stale tick steps a stopped count
    csel = cs;
    clk_en = 1'b1;
    fclr = '1;
    wr = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({cnt, flags, out_a, oe_a, out_b, oe_b}, '0, "reset");
    wr = {3'b100, ca};
    @(negedge clk);
    wr = {3'b010, cb};
    @(negedge clk);
    wr = {3'b001, ic};
    @(negedge clk);
    wr = '0;
    repeat (3) @(negedge clk);
    {wms, csel, oma, omb} = {m, cs, oa, ob};
    act = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      hit = !done && mw != '0 && cnt == at;
      clk_en = hit || !ren || $urandom_range(7) != 0;
      wr = hit ? mw : '0;
      done |= hit;
      {dir_a, dir_b, pd_a, pd_b} = 4'($urandom);
      fclr = 4'($urandom);
    end
    @(negedge clk);
    act = 1'b0;
    if (cs != 3'h0)
      chk(nchg > 2, 1, "counter ran");
    chk(mw == '0 || done, 1, "mid write");
    $display("test mode %h clock %0d done", m, cs);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Tests take about 86k cycles; a hang is cut off just short of 100k
  initial
  begin
    #1900000;
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [3:0]  fx [3];
    logic [3:0]  dx [5];
    logic [15:0] t;
    logic [15:0] r;
    fails = 0;
    comparisons = 0;
    fx = '{4'h5, 4'h6, 4'h7};
    dx = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
    {rst, clk_en, csel} = {1'b1, 1'b1, 3'h1};
    {wms, oma, omb, dir_a, dir_b, pd_a, pd_b, fclr, wr} = '0;
    void'($urandom(32'hFDC2));
    // Smallest TOP, toggle on A, spike on B, TOP raised through buffer
    run_case(4'hF, 3'h1, 2'h1, 2'h2, 16'h0003, 16'h0000, 16'h0000,
             {3'b100, 16'h0008}, 16'h0001, 200, 1);
    r = 16'($urandom_range(200, 16));
    run_case(4'hF, 3'h1, 2'h2, 2'h3, r, r, 16'h0000,
             {3'b010, 16'($urandom_range(r, 0))}, 16'h0005, 600, 1);
    // TOP lowered below the count: wraps through the full range
    run_case(4'hE, 3'h1, 2'h3, 2'h2, 16'h0020, 16'h0050, 16'h0040,
             {3'b001, 16'h0010}, 16'h0030, 66000, 0);
    foreach (fx[k])
    begin
      t = top_of(fx[k]);
      run_case(fx[k], 3'h1, 2'h2, 2'h3, 16'($urandom_range(t, 1)),
               16'($urandom_range(t, 1)), 16'h0000,
               {3'b010, 16'($urandom)}, 16'h0002, 3 * t + 100, 1);
    end
    foreach (dx[k])
    begin
      t = (dx[k] == 4'hA) ? 16'h0080 :
          (dx[k] == 4'hB) ? 16'h0060 : top_of(dx[k]);
      r = (dx[k] == 4'hB) ? t : 16'($urandom_range(t - 1, 1));
      run_case(dx[k], 3'h1, dx[k] == 4'hB ? 2'h1 : 2'h2, 2'h3, r,
               16'($urandom_range(t - 1, 1)), 16'h0080, '0, 16'h0000,
               3 * t + 40, 1);
    end
    for (int c = 0; c < 6; c++)
      run_case(4'h5, 3'(c), 2'h2, 2'h3, 16'h0010, 16'h0080, 16'h0000,
               '0, 16'h0000, c ? 5 * div_of(3'(c)) + 40 : 100, 1);
    tally_and_finish();
  end
endmodule // sfpwm_timer_tb
